// ==== hw/emwd_pkg.sv ====
// shared constants and carrier types for the external memory mode and wait decode block
package emwd_pkg;

    // apb register byte offsets
    localparam logic [7:0]  EMWD_WAIT_CTRL_OFS = 8'h00;
    localparam logic [7:0]  EMWD_OVLAY_OFS     = 8'h04;
    localparam logic [7:0]  EMWD_STATUS_OFS    = 8'h08;

    // wait control field positions
    localparam int          EMWD_PROGRAM_WAIT_COUNT_POS     = 0;
    localparam int          EMWD_DATA_WAIT_COUNT_POS     = 3;
    localparam int          EMWD_IOWAIT_POS    = 6;
    localparam int          EMWD_WS_MODE_POS   = 18;
    localparam int          EMWD_FIELD_W       = 3;

    // overlay register field positions
    localparam int          EMWD_PM_OVL_POS    = 0;
    localparam int          EMWD_DM_OVL_POS    = 4;
    localparam int          EMWD_OVL_W         = 4;

    // reset values
    localparam logic [2:0]  EMWD_WAIT_RST      = 3'h7;
    localparam logic [3:0]  EMWD_OVL_RST       = 4'h0;

    // boot words loaded by the byte dma engine
    localparam logic [5:0]  EMWD_BOOT_WORDS    = 6'h20;

    // overlay codes
    localparam logic [3:0]  EMWD_OVL_INT       = 4'h0;
    localparam logic [3:0]  EMWD_OVL_EXT1      = 4'h1;
    localparam logic [3:0]  EMWD_OVL_EXT2      = 4'h2;

    typedef enum logic [1:0] {EMWD_SP_PM, EMWD_SP_DM, EMWD_SP_IO} emwd_space_t;
    typedef enum logic [1:0] {EMWD_BOOT_STRAP, EMWD_BOOT_BYTE, EMWD_BOOT_HOST,
                              EMWD_BOOT_RUN} emwd_boot_t;
    typedef enum logic [1:0] {EMWD_ACC_IDLE, EMWD_ACC_STROBE, EMWD_ACC_DONE} emwd_acc_t;

    // core request toward external memory
    typedef struct packed {
        logic        valid;
        emwd_space_t space;
        logic        fetch;
        logic        write;
        logic [13:0] addr;
    } emwd_req_t;

    // external bus pins, selects and strobes active low
    typedef struct packed {
        logic [13:0] addr;
        logic        pm_sel_n;
        logic        dm_sel_n;
        logic        io_sel_n;
        logic        rd_n;
        logic        wr_n;
    } emwd_bus_t;

    localparam emwd_bus_t   EMWD_BUS_IDLE = '{addr: 14'h0000, default: 1'b1};

    // software configuration
    typedef struct packed {
        logic [2:0]      program_wait_count;
        logic [2:0]      data_wait_count;
        logic [3:0][2:0] io_wait;
        logic            ws_mode;
        logic [3:0]      pm_ovl;
        logic [3:0]      dm_ovl;
    } emwd_cfg_t;

    localparam emwd_cfg_t   EMWD_CFG_RST = '{program_wait_count: EMWD_WAIT_RST, data_wait_count: EMWD_WAIT_RST,
        io_wait: {4{EMWD_WAIT_RST}}, ws_mode: 1'b0, pm_ovl: EMWD_OVL_RST, dm_ovl: EMWD_OVL_RST};

endpackage

// ==== hw/emwd_top.sv ====
// external memory mode straps, overlay decode and wait state generation with apb registers
// What this block does
// - catch memory mode strap from the shared flag pin once, hold it thereafter
// - mode 0, boot straps 0: byte dma loads 32 words, run waits, full mode
// - mode 0, boot enable 1: no boot, run at external location 0, full mode
// - mode 1, boot straps 0: byte dma boots 32 words, host mode
// - mode 1, source 1: host loads memory, run waits for program word 0 write
// - host mode, ack strap 0: acknowledge driven both high and low
// - host mode, ack strap 1: acknowledge open drain, external pull-down
// - full mode offers two external 8K overlays over the data bus
// - program overlay 0 internal, 1 sets a13 low, 2 sets a13 high
// - data overlay decodes the same way in the upper address half
// - host mode: one address line only, no external program fetch
// - internal accesses finish in one cycle
// - external data accesses timed by data wait field and mode bit
// - mode bit 0 gives n wait states, 1 gives 2n+1
// - io space uses only the low eleven address bits
// - four io wait fields, one per io region
// - io region picked by address bits 10:9
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module emwd_top
    import emwd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        strap_boot_source,
    input  wire logic        strap_boot_enable,
    input  wire logic        shared_flag_pin_in,
    input  wire logic        strap_ack_drive,
    input  wire logic        host_dma_busy,
    input  wire logic        host_pm0_written,
    input  wire logic        byte_memory_dma_word_done,
    input  wire emwd_req_t   ext_req,
    output logic             ext_done,
    output logic             ext_refused,
    output logic             core_stall,
    output emwd_bus_t        ext_bus,
    output logic             host_acknowledge_out,
    output logic             host_acknowledge_oe_n,
    output logic             host_mode,
    output logic             core_run,
    output logic             exec_external,
    output logic             boot_dma_start
);

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic       captured;
        logic [1:0] fill;
        logic       host_mode;
        logic       ack_open;
        logic       boot_src;
        logic       boot_en;
        emwd_boot_t boot;
        logic [5:0] boot_cnt;
        logic       boot_start;
        logic       run;
        logic       exec_ext;
        logic       ack_out;
        logic       ack_oe_n;
        emwd_acc_t  acc;
        emwd_req_t  cur;
        logic [3:0] ws_cnt;
        logic       done;
        logic       refused;
        logic       stall;
        emwd_bus_t  bus;
        emwd_cfg_t  cfg;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
    } emwd_state_t;

    emwd_state_t st_reg;
    emwd_state_t st_next;

    // wait states from a field and the mode bit
    function automatic logic [3:0] emwd_ws(input logic [2:0] n, input logic mode);
        emwd_ws = mode ? {n, 1'b1} : {1'b0, n};
    endfunction

    logic [3:0] req_ovl;
    logic       req_upper;
    logic       req_ext;
    logic       req_bad;
    logic [3:0] req_ws;
    logic [13:0] req_addr;

    // decode of the incoming request
    always_comb begin
        req_ovl   = (ext_req.space == EMWD_SP_PM) ? st_reg.cfg.pm_ovl : st_reg.cfg.dm_ovl;
        req_upper = ext_req.addr[13];
        req_ext   = 1'b0;
        req_bad   = 1'b0;
        req_ws    = 4'h0;
        req_addr  = 14'h0000;
        unique case (ext_req.space)
            EMWD_SP_IO: begin
                req_ext  = 1'b1;
                req_bad  = st_reg.host_mode;
                req_addr = {3'h0, ext_req.addr[10:0]};
                req_ws   = emwd_ws(st_reg.cfg.io_wait[ext_req.addr[10:9]],
                                   st_reg.cfg.ws_mode);
            end
            default: begin
                req_ext  = req_upper && (req_ovl != EMWD_OVL_INT);
                req_bad  = req_ext && (req_ovl != EMWD_OVL_EXT1) &&
                           (req_ovl != EMWD_OVL_EXT2);
                req_bad  = req_bad || (req_ext && st_reg.host_mode &&
                           ext_req.fetch);
                req_addr = st_reg.host_mode ? {13'h0000, ext_req.addr[0]}
                           : {req_ovl == EMWD_OVL_EXT2, ext_req.addr[12:0]};
                req_ws   = emwd_ws((ext_req.space == EMWD_SP_DM) ? st_reg.cfg.data_wait_count
                           : st_reg.cfg.program_wait_count, st_reg.cfg.ws_mode);
            end
        endcase
    end

    // next state of straps, boot, access engine and registers
    always_comb begin
        st_next            = st_reg;
        st_next.sync1      = {strap_ack_drive, shared_flag_pin_in, strap_boot_enable,
                              strap_boot_source};
        st_next.sync2      = st_reg.sync1;
        st_next.sync3      = st_reg.sync2;
        st_next.fill       = st_reg.fill + {1'b0, st_reg.fill != 2'h3};
        st_next.boot_start = 1'b0;
        st_next.done       = 1'b0;
        st_next.refused    = 1'b0;
        st_next.pready     = 1'b0;
        st_next.pslverr    = 1'b0;

        // one-time strap capture once the synchroniser has settled
        if (!st_reg.captured && st_reg.fill == 2'h3 && st_reg.sync2 == st_reg.sync3) begin
            st_next.captured  = 1'b1;
            st_next.host_mode = st_reg.sync3[2];
            st_next.ack_open  = st_reg.sync3[3];
            st_next.boot_en   = st_reg.sync3[1];
            st_next.boot_src  = st_reg.sync3[0];
        end

        // boot sequencing
        unique case (st_reg.boot)
            EMWD_BOOT_STRAP: begin
                if (st_reg.captured) begin
                    if (!st_reg.boot_en && !st_reg.boot_src) begin
                        st_next.boot       = EMWD_BOOT_BYTE;
                        st_next.boot_start = 1'b1;
                        st_next.boot_cnt   = 6'h00;
                    end else if (st_reg.host_mode && st_reg.boot_src) begin
                        st_next.boot = EMWD_BOOT_HOST;
                    end else begin
                        st_next.boot     = EMWD_BOOT_RUN;
                        st_next.run      = 1'b1;
                        st_next.exec_ext = !st_reg.host_mode;
                    end
                end
            end
            EMWD_BOOT_BYTE: begin
                if (byte_memory_dma_word_done) begin
                    st_next.boot_cnt = st_reg.boot_cnt + 6'h01;
                    if (st_reg.boot_cnt + 6'h01 == EMWD_BOOT_WORDS) begin
                        st_next.boot = EMWD_BOOT_RUN;
                        st_next.run  = 1'b1;
                    end
                end
            end
            EMWD_BOOT_HOST: begin
                if (host_pm0_written) begin
                    st_next.boot = EMWD_BOOT_RUN;
                    st_next.run  = 1'b1;
                end
            end
            EMWD_BOOT_RUN: ;
        endcase

        // host acknowledge pin drive
        st_next.ack_out  = 1'b0;
        st_next.ack_oe_n = 1'b1;
        if (st_reg.captured && st_reg.host_mode) begin
            st_next.ack_out  = host_dma_busy;
            st_next.ack_oe_n = st_reg.ack_open ? !host_dma_busy
                                               : 1'b0;
        end

        // external access engine
        unique case (st_reg.acc)
            EMWD_ACC_IDLE: begin
                if (ext_req.valid) begin
                    st_next.cur   = ext_req;
                    st_next.stall = 1'b1;
                    if (req_ext && !req_bad) begin
                        st_next.acc       = EMWD_ACC_STROBE;
                        st_next.ws_cnt    = req_ws;
                        st_next.bus.addr  = req_addr;
                        st_next.bus.pm_sel_n = !(ext_req.space == EMWD_SP_PM);
                        st_next.bus.dm_sel_n = !(ext_req.space == EMWD_SP_DM);
                        st_next.bus.io_sel_n = !(ext_req.space == EMWD_SP_IO);
                        st_next.bus.rd_n  = ext_req.write;
                        st_next.bus.wr_n  = !ext_req.write;
                    end else begin
                        st_next.acc     = EMWD_ACC_DONE;
                        st_next.stall   = 1'b0;
                        st_next.done    = 1'b1;
                        st_next.refused = req_bad;
                    end
                end
            end
            EMWD_ACC_STROBE: begin
                if (st_reg.ws_cnt == 4'h0) begin
                    st_next.acc   = EMWD_ACC_DONE;
                    st_next.bus   = EMWD_BUS_IDLE;
                    st_next.stall = 1'b0;
                    st_next.done  = 1'b1;
                end else begin
                    st_next.ws_cnt = st_reg.ws_cnt - 4'h1;
                end
            end
            EMWD_ACC_DONE: begin
                st_next.acc = EMWD_ACC_IDLE;
            end
            default: begin
                st_next.acc = EMWD_ACC_IDLE;
            end
        endcase

        // apb setup phase: prepare answer for the access phase
        if (psel && !penable) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            unique case (paddr)
                EMWD_WAIT_CTRL_OFS: begin
                    st_next.prdata[EMWD_PROGRAM_WAIT_COUNT_POS +: EMWD_FIELD_W]    = st_reg.cfg.program_wait_count;
                    st_next.prdata[EMWD_DATA_WAIT_COUNT_POS +: EMWD_FIELD_W]    = st_reg.cfg.data_wait_count;
                    st_next.prdata[EMWD_IOWAIT_POS +: 4*EMWD_FIELD_W] = st_reg.cfg.io_wait;
                    st_next.prdata[EMWD_WS_MODE_POS]                  = st_reg.cfg.ws_mode;
                end
                EMWD_OVLAY_OFS: begin
                    st_next.prdata[EMWD_PM_OVL_POS +: EMWD_OVL_W] = st_reg.cfg.pm_ovl;
                    st_next.prdata[EMWD_DM_OVL_POS +: EMWD_OVL_W] = st_reg.cfg.dm_ovl;
                end
                EMWD_STATUS_OFS: begin
                    st_next.prdata[11:0] = {st_reg.boot_cnt, st_reg.exec_ext, st_reg.run,
                        st_reg.boot, st_reg.ack_open, st_reg.host_mode};
                    st_next.pslverr      = pwrite; // read only
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        // apb write takes effect at the completing edge, reserved bits dropped
        if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr) begin
            if (paddr == EMWD_WAIT_CTRL_OFS) begin
                st_next.cfg.program_wait_count   = pwdata[EMWD_PROGRAM_WAIT_COUNT_POS +: EMWD_FIELD_W];
                st_next.cfg.data_wait_count   = pwdata[EMWD_DATA_WAIT_COUNT_POS +: EMWD_FIELD_W];
                st_next.cfg.io_wait = pwdata[EMWD_IOWAIT_POS +: 4*EMWD_FIELD_W];
                st_next.cfg.ws_mode = pwdata[EMWD_WS_MODE_POS];
            end
            if (paddr == EMWD_OVLAY_OFS) begin
                st_next.cfg.pm_ovl = pwdata[EMWD_PM_OVL_POS +: EMWD_OVL_W];
                st_next.cfg.dm_ovl = pwdata[EMWD_DM_OVL_POS +: EMWD_OVL_W];
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.cfg      <= EMWD_CFG_RST;
            st_reg.bus      <= EMWD_BUS_IDLE;
            st_reg.ack_oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prdata                = st_reg.prdata;
    assign pready                = st_reg.pready;
    assign pslverr               = st_reg.pslverr;
    assign ext_done              = st_reg.done;
    assign ext_refused           = st_reg.refused;
    assign core_stall            = st_reg.stall;
    assign ext_bus               = st_reg.bus;
    assign host_acknowledge_out  = st_reg.ack_out;
    assign host_acknowledge_oe_n = st_reg.ack_oe_n;
    assign host_mode             = st_reg.host_mode;
    assign core_run              = st_reg.run;
    assign exec_external         = st_reg.exec_ext;
    assign boot_dma_start        = st_reg.boot_start;

    // helper: strobe length and wait load for the checks
    logic [4:0] strobe_len;
    logic [3:0] ws_loaded;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_len <= 5'h00;
            ws_loaded  <= 4'h0;
        end else if (st_reg.acc == EMWD_ACC_IDLE) begin
            strobe_len <= 5'h00;
            ws_loaded  <= req_ws;
        end else if (st_reg.acc == EMWD_ACC_STROBE) begin
            strobe_len <= strobe_len + 5'h01;
        end
    end

    default clocking emwd_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // checks
    strap_hold_a: assert property (st_reg.captured |=> st_reg.captured &&
        $stable(st_reg.host_mode) && $stable(st_reg.ack_open))
        else $error("memory mode changed after capture");
    byte_boot_a: assert property (st_reg.boot == EMWD_BOOT_BYTE |-> !st_reg.run &&
        st_reg.boot_cnt < EMWD_BOOT_WORDS)
        else $error("core ran before byte boot finished");
    no_boot_a: assert property ($rose(st_reg.run) && st_reg.boot_en && !st_reg.host_mode
        |-> st_reg.exec_ext)
        else $error("no-boot start not from external memory");
    host_boot_a: assert property (st_reg.boot == EMWD_BOOT_HOST && !host_pm0_written
        |=> !st_reg.run)
        else $error("core ran before program word 0 written");
    ack_drive_a: assert property (st_reg.captured && st_reg.host_mode && !st_reg.ack_open
        |=> !st_reg.ack_oe_n)
        else $error("acknowledge not actively driven");
    ack_open_a: assert property (st_reg.host_mode && st_reg.ack_open && !st_reg.ack_oe_n
        |-> st_reg.ack_out)
        else $error("open drain acknowledge drove low");
    ovl_bit_a: assert property (st_reg.acc == EMWD_ACC_STROBE && !st_reg.host_mode &&
        !st_reg.bus.pm_sel_n |-> st_reg.bus.addr[13] == (st_reg.cfg.pm_ovl == EMWD_OVL_EXT2))
        else $error("program overlay address bit wrong");
    wait_len_a: assert property (st_reg.acc == EMWD_ACC_STROBE ##1
        st_reg.acc == EMWD_ACC_DONE |-> strobe_len == {1'b0, ws_loaded} + 5'h01)
        else $error("strobe length differs from wait states");
    io_region_a: assert property ($rose(st_reg.acc == EMWD_ACC_STROBE) &&
        !st_reg.bus.io_sel_n |-> st_reg.ws_cnt == emwd_ws(
        st_reg.cfg.io_wait[st_reg.cur.addr[10:9]], st_reg.cfg.ws_mode))
        else $error("io region wait not applied");
    ovl_refuse_a: assert property (ext_req.valid && st_reg.acc == EMWD_ACC_IDLE &&
        ext_req.space == EMWD_SP_PM && ext_req.addr[13] && st_reg.cfg.pm_ovl > EMWD_OVL_EXT2
        |=> st_reg.refused && st_reg.bus.pm_sel_n)
        else $error("unsupported overlay started an access");
    host_fetch_a: assert property (ext_req.valid && st_reg.acc == EMWD_ACC_IDLE &&
        st_reg.host_mode && ext_req.fetch && req_ext |=> st_reg.refused)
        else $error("external fetch allowed in host mode");

    byte_boot_c: cover property (st_reg.boot == EMWD_BOOT_BYTE ##1 st_reg.run);
    long_wait_c: cover property (st_reg.acc == EMWD_ACC_STROBE && strobe_len == 5'h0f);
    refuse_c: cover property (st_reg.refused);
    host_boot_c: cover property (st_reg.boot == EMWD_BOOT_HOST ##1 st_reg.run);

endmodule

// ==== tb/emwd_partner.sv ====
// far side model: strap driver, boot byte memory, host dma port, acknowledge pull-down
`timescale 1ns/1ps
module emwd_partner (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic mode_strap,
    input  wire logic source_strap,
    input  wire logic boot_dma_start,
    input  wire logic host_mode,
    input  wire logic core_run,
    input  wire logic ack_out,
    input  wire logic ack_oe_n,
    output logic      shared_flag_pin_in,
    output logic      byte_memory_dma_word_done,
    output logic      host_pm0_written,
    output logic      host_dma_busy,
    output wire logic ack_wire
);
    logic [2:0] rel;
    logic [5:0] left;
    logic [4:0] hcnt;
    logic       tog;
    logic       hdone;
    // strap driven only around reset, then the flag pin toggles freely
    assign shared_flag_pin_in = (rel < 3'h6) ? mode_strap : tog;
    // released open drain line settles low through the pull-down
    assign ack_wire = ack_oe_n ? 1'b0 : ack_out;
    // byte memory answers every other cycle; host writes program word 0 once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rel, left, hcnt, tog, hdone} <= '0;
            {byte_memory_dma_word_done, host_pm0_written, host_dma_busy} <= '0;
        end else begin
            tog <= ~tog;
            if (rel != 3'h6) rel <= rel + 3'h1;
            byte_memory_dma_word_done <= 1'b0;
            host_pm0_written <= 1'b0;
            if (boot_dma_start) left <= 6'h20;
            else if (left != 6'h0 && !byte_memory_dma_word_done) begin
                byte_memory_dma_word_done <= 1'b1;
                left <= left - 6'h1;
            end
            if (host_mode && source_strap && !core_run && !hdone) begin
                hcnt <= hcnt + 5'h1;
                host_dma_busy <= 1'b1;
                if (hcnt == 5'h14) begin
                    {host_pm0_written, hdone, host_dma_busy} <= 3'b110;
                end
            end
        end
    end
endmodule

// ==== tb/emwd_tb_top.sv ====
// testbench for the external memory mode and wait decode block
`timescale 1ns/1ps
module emwd_tb_top;
    import emwd_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sa = 0, sb = 0, sc = 0, sd = 0, flag, busy, pm0, bdone;
    emwd_req_t   ext_req = '0;
    emwd_bus_t   ext_bus;
    logic        ext_done, ext_refused, core_stall, ack_out, ack_oe_n, ack_wire;
    logic        host_mode, core_run, exec_external, boot_dma_start;
    int          fail_count = 0, tests_run = 0;
    logic [3:0]  tbl [6] = '{4'b0000, 4'b0010, 4'b0100, 4'b0101, 4'b1100, 4'b1101};
    logic [13:0] ioa [4] = '{14'h01ff, 14'h0200, 14'h05ff, 14'h0600};
    always #5 pclk = ~pclk;
    emwd_top emwd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strap_boot_source(sa), .strap_boot_enable(sb),
        .shared_flag_pin_in(flag), .strap_ack_drive(sd), .host_dma_busy(busy),
        .host_pm0_written(pm0), .byte_memory_dma_word_done(bdone), .ext_req(ext_req),
        .ext_done(ext_done), .ext_refused(ext_refused), .core_stall(core_stall),
        .ext_bus(ext_bus), .host_acknowledge_out(ack_out), .host_acknowledge_oe_n(ack_oe_n),
        .host_mode(host_mode), .core_run(core_run), .exec_external(exec_external),
        .boot_dma_start(boot_dma_start));
    emwd_partner emwd_partner_i (.pclk(pclk), .presetn(presetn), .mode_strap(sc),
        .source_strap(sa), .boot_dma_start(boot_dma_start), .host_mode(host_mode),
        .core_run(core_run), .ack_out(ack_out), .ack_oe_n(ack_oe_n),
        .shared_flag_pin_in(flag), .byte_memory_dma_word_done(bdone), .host_pm0_written(pm0),
        .host_dma_busy(busy), .ack_wire(ack_wire));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, read data and error flag compared
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] er,
             input logic ee);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1); // answer before the limit
        if (!w) chk(prdata, er);
        chk(pslverr, ee);
        {psel, penable} <= 2'b00;
    endtask
    function int wt(input logic m, input int n);
        return m ? 2 * n + 1 : n;
    endfunction
    // one external request; w < 0 means no strobe expected
    task ext(input emwd_space_t sp, input logic fe, input logic wr, input logic [13:0] a,
             input int w, input logic rf, input logic [13:0] ea);
        int n, s, st;
        logic [13:0] ga;
        logic [4:0] gs;
        logic r;
        {n, s, st, ga, gs, r} = '0;
        @(posedge pclk);
        ext_req <= '{valid: 1'b1, space: sp, fetch: fe, write: wr, addr: a};
        do begin
            @(posedge pclk);
            n++;
            if (ext_bus.rd_n === 1'b0 || ext_bus.wr_n === 1'b0) begin
                s++;
                ga = ext_bus.addr;
                gs = {ext_bus.pm_sel_n, ext_bus.dm_sel_n, ext_bus.io_sel_n, ext_bus.rd_n,
                      ext_bus.wr_n};
            end
            st += core_stall;
            r = ext_refused;
        end while (ext_done !== 1'b1 && n < 60);
        ext_req <= '0;
        @(posedge pclk);
        chk(n, (w < 0) ? 2 : w + 3);
        chk(s, (w < 0) ? 0 : w + 1);
        chk(st, (w < 0) ? 0 : w + 1);
        chk(r, rf);
        if (w >= 0) chk((sp == EMWD_SP_IO) ? {3'h0, ga[10:0]} : ga, ea);
        if (w >= 0) chk(gs, {(sp == EMWD_SP_PM) ? 3'b011 : (sp == EMWD_SP_DM) ? 3'b101 : 3'b110,
                             wr, ~wr});
    endtask
    // reset with straps {ack drive, memory mode, boot enable, boot source}
    task boot(input logic [3:0] s);
        int n, bc, hc;
        {n, bc, hc} = '0;
        @(posedge pclk);
        presetn <= 1'b0;
        {sd, sc, sb, sa} <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            bc += bdone;
            hc += pm0;
        end while (core_run !== 1'b1 && n < 300);
        chk(bc, (!s[1] && !s[0]) ? 32 : 0);
        chk(hc, (s[2] && s[0]) ? 1 : 0);
        chk(exec_external, !s[2] && s[1]);
        repeat (10) @(posedge pclk);
        chk(host_mode, s[2]);
        if (s[2]) chk(ack_oe_n, s[3]);
        if (s[2]) chk(ack_wire, 1'b0);
        $display("boot test %b done", s);
    endtask
    task print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        print_verdict();
    end
    initial begin
        foreach (tbl[i]) boot(tbl[i]);
        apb(1'b1, EMWD_OVLAY_OFS, 32'h11, 32'h0, 1'b0);
        ext(EMWD_SP_PM, 1'b1, 1'b0, 14'h2000, -1, 1'b1, 14'h0);
        ext(EMWD_SP_IO, 1'b0, 1'b0, 14'h0010, -1, 1'b1, 14'h0);
        $display("host mode test done");
        boot(4'b0010);
        apb(1'b0, EMWD_WAIT_CTRL_OFS, 32'h0, 32'h0003ffff, 1'b0);
        apb(1'b0, EMWD_OVLAY_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, EMWD_STATUS_OFS, 32'h1, 32'h0, 1'b1);
        apb(1'b0, EMWD_STATUS_OFS, 32'h0, 32'h3c, 1'b0);
        $display("register test done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, EMWD_WAIT_CTRL_OFS, {13'h0, m[0], 12'o7513, 3'h0, 3'h2}, 32'h0, 1'b0);
            apb(1'b1, EMWD_OVLAY_OFS, 32'h12, 32'h0, 1'b0);
            ext(EMWD_SP_DM, 1'b0, 1'b0, 14'h2005, wt(m[0], 0), 1'b0, 14'h0005);
            ext(EMWD_SP_PM, 1'b0, 1'b0, 14'h2abc, wt(m[0], 2), 1'b0, 14'h2abc);
            apb(1'b1, EMWD_OVLAY_OFS, 32'h22, 32'h0, 1'b0);
            ext(EMWD_SP_DM, 1'b0, 1'b1, 14'h3fff, wt(m[0], 0), 1'b0, 14'h3fff);
            foreach (ioa[i])
                ext(EMWD_SP_IO, 1'b0, 1'b0, ioa[i], wt(m[0], (12'o7513 >> (3 * i)) & 7), 1'b0,
                    {3'h0, ioa[i][10:0]});
            apb(1'b1, EMWD_OVLAY_OFS, 32'h33, 32'h0, 1'b0);
            ext(EMWD_SP_DM, 1'b0, 1'b0, 14'h2000, -1, 1'b1, 14'h0);
            ext(EMWD_SP_DM, 1'b0, 1'b0, 14'h0005, -1, 1'b0, 14'h0);
            $display("wait mode %0d test done", m);
        end
        print_verdict();
    end
endmodule
